// File: hdl/etg_pkg.sv
/*
  Shared constants and types of the external trigger and gate control:
  register offsets, field layouts, reset values and operating modes.
  Assumes a 32-bit plain register port with byte addresses.
*/
`default_nettype none
package etg_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam int         ADDR_W      = 8;
  localparam int         DATA_W      = 32;
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_THRESH  = 8'h04;
  localparam logic [7:0] OFF_PERIOD  = 8'h08;
  localparam logic [7:0] OFF_WIDTH0  = 8'h0C;
  localparam logic [7:0] OFF_WIDTH1  = 8'h10;
  localparam logic [7:0] OFF_BURST   = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;

  // ---------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_MODE_MSB  = 2;
  localparam int CTRL_FALL_BIT  = 3;
  localparam int CTRL_MAN_BIT   = 4;
  localparam int THR_W          = 7;
  localparam int TIME_W         = 16;
  localparam int BURST_W        = 8;
  localparam int NUM_CH         = 2;
  localparam int ST_ACT_BIT     = 0;
  localparam int ST_OUT_LSB     = 1;
  localparam int ST_GATE_BIT    = 3;
  localparam int ST_MODE_LSB    = 4;

  // Threshold in steps of 0.1 V, two's complement
  localparam logic signed [6:0] THR_MIN   = -7'sd50;
  localparam logic signed [6:0] THR_MAX   = 7'sd50;
  localparam logic signed [6:0] THR_RESET = 7'sd0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] PERIOD_RESET = 16'h0064;
  localparam logic [15:0] WIDTH_RESET  = 16'h000A;
  localparam logic [7:0]  BURST_RESET  = 8'h04;
  localparam logic [7:0]  BURST_ONE    = 8'h01;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ETG_AUTO   = 3'b000,
    ETG_TRIGGERED_MODE   = 3'b001,
    ETG_GATE   = 3'b010,
    ETG_BURST  = 3'b011,
    ETG_EWIDTH = 3'b100
  } etg_mode_t;

  localparam etg_mode_t MODE_LAST = ETG_EWIDTH;

  typedef enum logic [0:0] {
    ETG_IDLE = 1'b0,
    ETG_RUN  = 1'b1
  } etg_eng_state_t;

  typedef struct packed {
    logic      manual_sel;
    logic      falling_slope_select;
    etg_mode_t mode;
  } etg_ctrl_t;

  typedef struct packed {
    logic [15:0] period;
    logic [15:0] width;
    logic [7:0]  count;
  } etg_timing_t;

  localparam etg_ctrl_t CTRL_RESET = '{1'b0, 1'b0, ETG_AUTO};

endpackage
`default_nettype wire

// File: hdl/etg_sync.sv
/*
  Three-stage synchroniser with agreement filter and edge pulses.
  Assumes an input asynchronous to clk_sys_i.
*/
`default_nettype none
module etg_sync (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output var  logic level_o,
  output var  logic rise_o,
  output var  logic fall_o
);

  logic meta_q;
  logic s2_q;
  logic s3_q;

  // ---------------------------------------------------------------
  // Sampling chain
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
    end else begin
      meta_q <= async_i;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
    end
  end

  // ---------------------------------------------------------------
  // Filtered level and single edge pulses
  // ---------------------------------------------------------------
  // A change is taken only when stages two and three agree, so each
  // edge of a level held two cycles or more yields exactly one pulse.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (s2_q == s3_q && s3_q != level_o) begin
        level_o <= s3_q;
        rise_o  <= s3_q;
        fall_o  <= ~s3_q;
      end
    end
  end

endmodule
`default_nettype wire

// File: hdl/etg_engine.sv
/*
  Pulse engine for one channel: starts a pulse train on fire_i, runs
  tim_i.count pulses, keeps repeating while cont_i is high, and always ends
  on a period boundary so the last pulse is never cut short.
  Assumes fire_i and cont_i come from logic on the same clock.
*/
`default_nettype none
module etg_engine (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire logic                fire_i,
  input  wire logic                cont_i,
  input  wire etg_pkg::etg_timing_t tim_i,
  output var  logic                pulse_o,
  output var  logic                busy_o
);

  etg_pkg::etg_eng_state_t state_q;
  etg_pkg::etg_eng_state_t state_d;
  logic [15:0]             cnt_q;
  logic [15:0]             cnt_d;
  logic [7:0]              left_q;
  logic [7:0]              left_d;
  logic [15:0]             last;

  assign last = (tim_i.period == 16'h0000) ? 16'h0000
                                           : tim_i.period - 16'h0001;

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    left_d  = left_q;
    case (state_q)
      etg_pkg::ETG_IDLE: begin
        if (fire_i) begin
          state_d = etg_pkg::ETG_RUN;
          cnt_d   = 16'h0000;
          left_d  = (tim_i.count == 8'h00) ? 8'h00
                                           : tim_i.count - 8'h01;
        end
      end
      etg_pkg::ETG_RUN: begin
        if (cnt_q >= last) begin
          // Stopping only here lets a closing gate finish the pulse
          if (cont_i || left_q != 8'h00) begin
            cnt_d = 16'h0000;
            if (left_q != 8'h00) begin
              left_d = left_q - 8'h01;
            end
          end else begin
            state_d = etg_pkg::ETG_IDLE;
          end
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      default: begin
        state_d = etg_pkg::ETG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= etg_pkg::ETG_IDLE;
      cnt_q   <= 16'h0000;
      left_q  <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      left_q  <= left_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pulse_o <= 1'b0;
      busy_o  <= 1'b0;
    end else begin
      pulse_o <= (state_d == etg_pkg::ETG_RUN) && (cnt_d < tim_i.width);
      busy_o  <= (state_d == etg_pkg::ETG_RUN);
    end
  end

endmodule
`default_nettype wire

// File: hdl/etg_top.sv
/*
  External trigger and gate control of a two-channel pulse generator:
  slope selection, mode stepping, gate tracking, external width
  pass-through and the register port.
  Assumes the input comparator sits outside and delivers the
  thresholded input as a logic level; threshold_o feeds its reference.
*/
`default_nettype none
module etg_top (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output var  logic [31:0] rdata_o,
  input  wire logic        external_trigger_input_i,
  input  wire logic        manual_trigger_key_i,
  input  wire logic        mode_key_i,
  output var  logic [6:0]  threshold_o,
  output var  logic [1:0]  pulse_o,
  output var  logic [2:0]  mode_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  etg_pkg::etg_ctrl_t    ctrl_q;
  logic signed [6:0]     thr_q;
  logic [15:0]           period_q;
  logic [15:0]           width_q [etg_pkg::NUM_CH];
  logic [7:0]            burst_q;
  logic                  gate_open_q;

  logic                  ext_lvl;
  logic                  ext_rise;
  logic                  ext_fall;
  logic                  man_lvl;
  logic                  man_rise;
  logic                  man_fall;
  logic                  key_rise;

  logic                  act_lvl;
  logic                  lead_edge;
  logic                  trail_edge;
  logic                  fire;
  logic                  cont;
  logic [1:0]            eng_pulse;
  logic [1:0]            eng_busy;
  logic signed [6:0]     thr_wr;
  etg_pkg::etg_mode_t    mode_next;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  etg_sync u_sync_ext (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   (external_trigger_input_i),
    .level_o   (ext_lvl),
    .rise_o    (ext_rise),
    .fall_o    (ext_fall)
  );

  etg_sync u_sync_man (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   (manual_trigger_key_i),
    .level_o   (man_lvl),
    .rise_o    (man_rise),
    .fall_o    (man_fall)
  );

  etg_sync u_sync_key (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   (mode_key_i),
    .level_o   (),
    .rise_o    (key_rise),
    .fall_o    ()
  );

  // ---------------------------------------------------------------
  // Source and slope selection
  // ---------------------------------------------------------------
  // The key is pressed-active, so slope does not apply to it.
  always_comb begin
    if (ctrl_q.manual_sel) begin
      act_lvl    = man_lvl;
      lead_edge  = man_rise;
      trail_edge = man_fall;
    end else if (ctrl_q.falling_slope_select) begin
      act_lvl    = ~ext_lvl;
      lead_edge  = ext_fall;
      trail_edge = ext_rise;
    end else begin
      act_lvl    = ext_lvl;
      lead_edge  = ext_rise;
      trail_edge = ext_fall;
    end
  end

  // ---------------------------------------------------------------
  // Gate tracking
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      gate_open_q <= 1'b0;
    end else if (ctrl_q.mode != etg_pkg::ETG_GATE) begin
      gate_open_q <= 1'b0;
    end else if (lead_edge) begin
      gate_open_q <= 1'b1;
    end else if (trail_edge) begin
      gate_open_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Engine control, shared by both channels
  // ---------------------------------------------------------------
  always_comb begin
    fire = 1'b0;
    cont = 1'b0;
    case (ctrl_q.mode)
      etg_pkg::ETG_AUTO: begin
        // Free run; input edges are never looked at here
        fire = ~eng_busy[0];
        cont = 1'b1;
      end
      etg_pkg::ETG_TRIGGERED_MODE,
      etg_pkg::ETG_BURST: begin
        fire = lead_edge;
      end
      etg_pkg::ETG_GATE: begin
        fire = lead_edge;
        cont = gate_open_q | lead_edge;
      end
      default: begin
        fire = 1'b0;
      end
    endcase
  end

  genvar ch;
  generate
    for (ch = 0; ch < etg_pkg::NUM_CH; ch++) begin : g_ch
      etg_pkg::etg_timing_t tim;
      assign tim.period = period_q;
      assign tim.width  = width_q[ch];
      assign tim.count  = (ctrl_q.mode == etg_pkg::ETG_BURST) ? burst_q
                                                  : etg_pkg::BURST_ONE;
      etg_engine u_eng (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .fire_i    (fire),
        .cont_i    (cont),
        .tim_i     (tim),
        .pulse_o   (eng_pulse[ch]),
        .busy_o    (eng_busy[ch])
      );

      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          pulse_o[ch] <= 1'b0;
        end else if (ctrl_q.mode == etg_pkg::ETG_EWIDTH) begin
          pulse_o[ch] <= act_lvl;
        end else begin
          pulse_o[ch] <= eng_pulse[ch];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Mode register and key stepping
  // ---------------------------------------------------------------
  assign mode_next = (ctrl_q.mode >= etg_pkg::MODE_LAST) ? etg_pkg::ETG_AUTO
                   : etg_pkg::etg_mode_t'(ctrl_q.mode + 3'h1);

  // One mode field for both channels; a key press wins over a write.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_q <= etg_pkg::CTRL_RESET;
    end else begin
      if (wr_i && hit(addr_i, etg_pkg::OFF_CTRL)) begin
        ctrl_q.manual_sel           <= wdata_i[etg_pkg::CTRL_MAN_BIT];
        ctrl_q.falling_slope_select <= wdata_i[etg_pkg::CTRL_FALL_BIT];
        if (wdata_i[etg_pkg::CTRL_MODE_MSB:etg_pkg::CTRL_MODE_LSB]
            <= etg_pkg::MODE_LAST) begin
          ctrl_q.mode <= etg_pkg::etg_mode_t'(
            wdata_i[etg_pkg::CTRL_MODE_MSB:etg_pkg::CTRL_MODE_LSB]);
        end
      end
      if (key_rise) begin
        ctrl_q.mode <= mode_next;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_o <= etg_pkg::ETG_AUTO;
    end else begin
      mode_o <= ctrl_q.mode;
    end
  end

  // ---------------------------------------------------------------
  // Threshold and timing registers
  // ---------------------------------------------------------------
  assign thr_wr = signed'(wdata_i[etg_pkg::THR_W-1:0]);

  // Out-of-range writes clamp rather than wrap, so the reference
  // never leaves the comparator's span.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      thr_q <= etg_pkg::THR_RESET;
    end else if (wr_i && hit(addr_i, etg_pkg::OFF_THRESH)) begin
      if (thr_wr < etg_pkg::THR_MIN) begin
        thr_q <= etg_pkg::THR_MIN;
      end else if (thr_wr > etg_pkg::THR_MAX) begin
        thr_q <= etg_pkg::THR_MAX;
      end else begin
        thr_q <= thr_wr;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      threshold_o <= etg_pkg::THR_RESET;
    end else begin
      threshold_o <= thr_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      period_q   <= etg_pkg::PERIOD_RESET;
      width_q[0] <= etg_pkg::WIDTH_RESET;
      width_q[1] <= etg_pkg::WIDTH_RESET;
      burst_q    <= etg_pkg::BURST_RESET;
    end else if (wr_i) begin
      if (hit(addr_i, etg_pkg::OFF_PERIOD)) begin
        period_q <= wdata_i[etg_pkg::TIME_W-1:0];
      end
      if (hit(addr_i, etg_pkg::OFF_WIDTH0)) begin
        width_q[0] <= wdata_i[etg_pkg::TIME_W-1:0];
      end
      if (hit(addr_i, etg_pkg::OFF_WIDTH1)) begin
        width_q[1] <= wdata_i[etg_pkg::TIME_W-1:0];
      end
      if (hit(addr_i, etg_pkg::OFF_BURST)) begin
        burst_q <= wdata_i[etg_pkg::BURST_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        case (addr_i)
          etg_pkg::OFF_CTRL: begin
            rdata_o[etg_pkg::CTRL_MODE_MSB:etg_pkg::CTRL_MODE_LSB]
              <= ctrl_q.mode;
            rdata_o[etg_pkg::CTRL_FALL_BIT] <= ctrl_q.falling_slope_select;
            rdata_o[etg_pkg::CTRL_MAN_BIT]  <= ctrl_q.manual_sel;
          end
          etg_pkg::OFF_THRESH: begin
            rdata_o[etg_pkg::THR_W-1:0] <= thr_q;
          end
          etg_pkg::OFF_PERIOD: begin
            rdata_o[etg_pkg::TIME_W-1:0] <= period_q;
          end
          etg_pkg::OFF_WIDTH0: begin
            rdata_o[etg_pkg::TIME_W-1:0] <= width_q[0];
          end
          etg_pkg::OFF_WIDTH1: begin
            rdata_o[etg_pkg::TIME_W-1:0] <= width_q[1];
          end
          etg_pkg::OFF_BURST: begin
            rdata_o[etg_pkg::BURST_W-1:0] <= burst_q;
          end
          etg_pkg::OFF_STATUS: begin
            rdata_o[etg_pkg::ST_ACT_BIT]                  <= act_lvl;
            rdata_o[etg_pkg::ST_OUT_LSB+1:etg_pkg::ST_OUT_LSB] <= pulse_o;
            rdata_o[etg_pkg::ST_GATE_BIT]                 <= gate_open_q;
            rdata_o[etg_pkg::ST_MODE_LSB+2:etg_pkg::ST_MODE_LSB]
              <= ctrl_q.mode;
          end
          default: begin
            rdata_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/etg_assertions.sv
/*
  Checker for the trigger and gate control top: slope, mode stepping,
  width pass-through and gate pulse behaviour seen at the ports.
  Assumes inputs change just after rising clock edges.
*/
`default_nettype none
module etg_assertions (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        external_trigger_input_i,
  input wire logic        manual_trigger_key_i,
  input wire logic        mode_key_i,
  input wire logic [6:0]  threshold_o,
  input wire logic [1:0]  pulse_o,
  input wire logic [2:0]  mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Shadow of control bits and pulse length
  // --------------------------------------------------------------
  logic        fall_q;
  logic        man_q;
  logic [15:0] w0_q;
  logic [15:0] run_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fall_q <= 1'b0;
      man_q  <= 1'b0;
      w0_q   <= etg_pkg::WIDTH_RESET;
    end else if (wr_i && addr_i == etg_pkg::OFF_CTRL) begin
      fall_q <= wdata_i[3];
      man_q  <= wdata_i[4];
    end else if (wr_i && addr_i == etg_pkg::OFF_WIDTH0) begin
      w0_q <= wdata_i[15:0];
    end
  end

  // Length of the current high run of channel 0
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !pulse_o[0]) begin
      run_q <= 16'h0000;
    end else begin
      run_q <= run_q + 16'h0001;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_lead;
    !man_q && (fall_q ? $fell(external_trigger_input_i)
                      : $rose(external_trigger_input_i));
  endsequence
  sequence s_trail;
    !man_q && (fall_q ? $rose(external_trigger_input_i)
                      : $fell(external_trigger_input_i));
  endsequence

  property p_thr_range;
    $signed(threshold_o) >= -7'sd50 && $signed(threshold_o) <= 7'sd50;
  endproperty
  property p_mode_legal;
    mode_o <= 3'h4;
  endproperty
  property p_mode_step;
    $changed(mode_o) && !$past(wr_i) && !$past(wr_i, 2) |->
      mode_o == (($past(mode_o) == 3'h4) ? 3'h0 : $past(mode_o) + 3'h1);
  endproperty
  property p_ewidth_on;
    mode_o == 3'h4 ##0 s_lead |-> ##[3:8] pulse_o == 2'b11;
  endproperty
  property p_ewidth_off;
    mode_o == 3'h4 ##0 s_trail |-> ##[3:8] pulse_o == 2'b00;
  endproperty
  property p_fire;
    (mode_o inside {3'h1, 3'h2, 3'h3}) && pulse_o == 2'b00 ##0 s_lead
      |-> ##[4:9] pulse_o[0];
  endproperty
  property p_manual_block;
    mode_o == 3'h1 && man_q && !manual_trigger_key_i && pulse_o == 2'b00
      ##0 $rose(external_trigger_input_i) |=> (pulse_o == 2'b00) [*8];
  endproperty
  property p_gate_width;
    mode_o == 3'h2 && $fell(pulse_o[0]) |-> run_q == w0_q;
  endproperty

  a_thr_range: assert property (p_thr_range)
    else $error("threshold outside range");
  a_mode_legal: assert property (p_mode_legal)
    else $error("mode code out of range");
  a_mode_step: assert property (p_mode_step)
    else $error("mode did not step cyclically");
  a_ewidth_on: assert property (p_ewidth_on)
    else $error("width mode output not switched on");
  a_ewidth_off: assert property (p_ewidth_off)
    else $error("width mode output not switched off");
  a_fire: assert property (p_fire)
    else $error("leading edge did not start a pulse");
  a_manual_block: assert property (p_manual_block)
    else $error("external input acted in manual use");
  a_gate_width: assert property (p_gate_width)
    else $error("gated pulse cut short");
endmodule
`default_nettype wire

// File: tb/etg_src_model.sv
/*
  External trigger or gate source: after a fire request it waits a
  given latency, then holds the active level for a given length.
  Assumes the bench requests with one-cycle pulses on the clock.
*/
`default_nettype none
module etg_src_model (
  input  wire logic       clk_sys_i,
  input  wire logic       fire_i,
  input  wire logic       idle_lvl_i,
  input  wire logic [3:0] lat_i,
  input  wire logic [7:0] hold_i,
  output var  logic       ext_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q = 4'h0;
  logic [7:0] hold_q = 8'h00;

  initial ext_o = 1'b0;

  // Random latency lets the edge fall anywhere against the engine phase
  always @(posedge clk_sys_i) begin
    if (fire_i) begin
      wait_q <= lat_i;
      hold_q <= hold_i;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (hold_q != 8'h00) begin
      hold_q <= hold_q - 8'h01;
    end
    ext_o <= (!fire_i && wait_q == 4'h0 && hold_q != 8'h00) ?
             !idle_lvl_i : idle_lvl_i;
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/*
  Self-checking bench of the trigger and gate control top.
  Assumes the source model and the checker are compiled before it.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys_i   = 1'b0;
  logic        rst_i       = 1'b1;
  logic [7:0]  addr_i      = 8'h00;
  logic [31:0] wdata_i     = 32'h00000000;
  logic        wr_i        = 1'b0;
  logic        rd_i        = 1'b0;
  logic        man_key     = 1'b0;
  logic        mode_key    = 1'b0;
  logic        fire        = 1'b0;
  logic        idle_lvl    = 1'b0;
  logic [3:0]  lat         = 4'h0;
  logic [7:0]  hold        = 8'h00;
  logic        ext;
  logic [31:0] rdata_o;
  logic [6:0]  threshold_o;
  logic [1:0]  pulse_o;
  logic [2:0]  mode_o;
  int          mismatches  = 0;
  int          checks_done = 0;
  int          hi0;
  int          hi1;

  always #5 clk_sys_i = ~clk_sys_i;

  etg_top dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .external_trigger_input_i(ext), .manual_trigger_key_i(man_key),
    .mode_key_i(mode_key), .threshold_o(threshold_o),
    .pulse_o(pulse_o), .mode_o(mode_o));
  etg_src_model src_u (.clk_sys_i(clk_sys_i), .fire_i(fire),
    .idle_lvl_i(idle_lvl), .lat_i(lat), .hold_i(hold), .ext_o(ext));

  // ----------------------------------------------------------------
  // Bus, stimulus and checking tasks
  // ----------------------------------------------------------------
  task automatic check(input string w, input logic [31:0] e,
                       input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    check("register read", e, rdata_o);
  endtask
  task automatic watch(input int n);
    repeat (n) begin
      @(negedge clk_sys_i);
      if (pulse_o[0] === 1'b1) hi0++;
      if (pulse_o[1] === 1'b1) hi1++;
    end
  endtask
  task automatic src(input int h, input int n);
    @(posedge clk_sys_i);
    hold <= h[7:0];
    lat  <= 4'($urandom_range(15));
    fire <= 1'b1;
    @(posedge clk_sys_i);
    fire <= 1'b0;
    hi0 = 0;
    hi1 = 0;
    watch(n);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [6:0] clamp(input int v);
    if (v > 50) return 7'h32;
    if (v < -50) return 7'h4E;
    return v[6:0];
  endfunction
  // High cycles of one channel: period 20, burst 3, per-channel width w
  function automatic int exp_hi(input int m, input int h, input int w);
    case (m)
      1: return w;
      2: return w * ((h + 19) / 20);
      3: return 3 * w;
      default: return h;
    endcase
  endfunction

  initial begin
    logic [7:0]  offs [7];
    logic [31:0] vals [7];
    int          v;
    int          h;
    offs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
    vals = '{32'h0, 32'h0, 32'h64, 32'hA, 32'hA, 32'h4, 32'h0};
    void'($urandom(32'hBCEA));
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    foreach (offs[i]) rd_chk(offs[i], vals[i]);
    for (int i = 0; i < 6; i++) begin
      v = (i < 2) ? (i == 0 ? 63 : -64) : int'($urandom_range(100)) - 50;
      reg_wr(etg_pkg::OFF_THRESH, 32'(v));
      // Output register lags the threshold register by one cycle
      repeat (2) @(negedge clk_sys_i);
      check("threshold_o", {25'h0, clamp(v)}, {25'h0, threshold_o});
    end
    reg_wr(etg_pkg::OFF_PERIOD, 32'h14);
    reg_wr(etg_pkg::OFF_WIDTH0, 32'h5);
    reg_wr(etg_pkg::OFF_WIDTH1, 32'h7);
    reg_wr(etg_pkg::OFF_BURST, 32'h3);
    repeat (60) @(posedge clk_sys_i);
    // Free run repeats with no idle cycle: watch whole periods only
    src(30, 60);
    check("free run ch0", 32'd15, hi0);
    check("free run ch1", 32'd21, hi1);
    @(posedge clk_sys_i);
    for (int i = 1; i < 6; i++) begin
      mode_key <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      mode_key <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
      check("mode_o", 32'(i % 5), {29'h0, mode_o});
    end
    reg_wr(etg_pkg::OFF_CTRL, 32'h7);
    @(negedge clk_sys_i);
    check("mode_o", 32'h0, {29'h0, mode_o});
    for (int m = 1; m < 5; m++) begin
      for (int s = 0; s < 2; s++) begin
        reg_wr(etg_pkg::OFF_CTRL, 32'h0);
        idle_lvl <= s[0];
        repeat (30) @(posedge clk_sys_i);
        reg_wr(etg_pkg::OFF_CTRL, 32'(m | (s << 3)));
        repeat (30) @(posedge clk_sys_i);
        h = (m == 2) ? 20 * $urandom_range(1, 3) + 10 : $urandom_range(12, 40);
        src(h, h + 90);
        check("ch0 high", exp_hi(m, h, 5), hi0);
        check("ch1 high", exp_hi(m, h, 7), hi1);
      end
    end
    reg_wr(etg_pkg::OFF_CTRL, 32'h0);
    idle_lvl <= 1'b0;
    repeat (30) @(posedge clk_sys_i);
    reg_wr(etg_pkg::OFF_CTRL, 32'h11);
    repeat (30) @(posedge clk_sys_i);
    src(30, 60);
    check("manual ext ch0", 32'd0, hi0);
    reg_wr(etg_pkg::OFF_CTRL, 32'h12);
    repeat (10) @(posedge clk_sys_i);
    hi0 = 0;
    hi1 = 0;
    man_key <= 1'b1;
    watch(50);
    @(posedge clk_sys_i);
    man_key <= 1'b0;
    watch(90);
    check("manual gate ch0", 32'd15, hi0);
    check("manual gate ch1", 32'd21, hi1);
    end_of_test();
  end
endmodule

bind etg_top etg_assertions chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .external_trigger_input_i(external_trigger_input_i),
  .manual_trigger_key_i(manual_trigger_key_i), .mode_key_i(mode_key_i),
  .threshold_o(threshold_o), .pulse_o(pulse_o), .mode_o(mode_o));
`default_nettype wire
